// ### core/stzs_pkg.sv
package stzs_pkg;

  // ***************************************************************
  // Widths and constants
  // ***************************************************************
  localparam int unsigned EDC_W       = 16;
  localparam int unsigned ROM_SUM_W   = 32;
  localparam int unsigned RNG_BLK_W   = 64;
  localparam int unsigned KAT_COUNT   = 6;
  localparam int unsigned NV_ADDR_W   = 8;
  localparam int unsigned KEY_W       = 32;
  localparam logic [NV_ADDR_W-1:0] NV_LAST_ADDR = 8'hff;
  localparam logic [KAT_COUNT-1:0] KAT_ALL      = 6'h3f;
  localparam logic [KEY_W-1:0]     KEY_RESET    = 32'h0000_0000;
  localparam logic [RNG_BLK_W-1:0] BLK_RESET    = 64'h0000_0000_0000_0000;
  // Erase makes two passes: wipe, then overwrite
  localparam logic [7:0] NV_ERASE_PAT  = 8'h00;
  localparam logic [7:0] NV_FILL_PAT   = 8'hff;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [2:0] {
    ST_RESUME = 3'b000,
    ST_SEED   = 3'b001,
    ST_KAT    = 3'b011,
    ST_CRC    = 3'b010,
    ST_RUN    = 3'b110,
    ST_ERASE  = 3'b111,
    ST_MUTE   = 3'b101
  } stzs_state_type;

  typedef struct packed {
    logic                 we;
    logic [NV_ADDR_W-1:0] addr;
    logic [7:0]           data;
  } stzs_nv_wr_type;

  typedef struct packed {
    logic                 valid;
    logic [RNG_BLK_W-1:0] block;
  } stzs_rng_type;

endpackage : stzs_pkg

// ### core/stzs_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Key install or replace overwrites the stored key with a fresh random value.
// - Erase command wipes then overwrites the whole nonvolatile store.
// - Interrupted erase resumes at next power-on before any access.
// - Session key cleared on channel close or power loss.
// - Power-up takes fresh true-random seed and seed key.
// - Seed values volatile only, cleared at reset, never output.
// - Output blocked while any self-test runs.
// - Any test failure enters silent state ignoring commands.
// - Silent state left only by hard reset.
// - Each reset sends an answer-to-reset, then runs power-up tests.
// - No start-up path skips the self-tests.
// - Each algorithm test passes only when result equals stored answer.
// - Generator test seeds fixed values and compares stored result.
// - Nonvolatile firmware checked against stored 16-bit checksum.
// - Read-only firmware checked against stored 32-bit checksum.
// - First command runs only after all power-up tests pass.
// - Each generator output block compared against the previous block.
// - Loaded application authenticated; failure enters error state.
module stzs_sequencer
  import stzs_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic                  erase_pending,
  output logic                       erase_pending_set,
  output logic                       erase_pending_clr,
  input  wire logic                  erase_cmd,
  output stzs_nv_wr_type             nv_wr,
  input  wire logic                  trng_ready,
  input  wire stzs_rng_type          trng,
  input  wire stzs_rng_type          drng,
  output logic                       drng_seed_load,
  output logic [RNG_BLK_W-1:0]       drng_seed_q,
  output logic [RNG_BLK_W-1:0]       drng_seed_key_q,
  input  wire logic                  kat_done,
  input  wire logic [KAT_COUNT-1:0]  kat_result_eq,
  input  wire logic                  crc_done,
  input  wire logic [EDC_W-1:0]      nv_edc_calc,
  input  wire logic [EDC_W-1:0]      nv_edc_stored,
  input  wire logic [ROM_SUM_W-1:0]  rom_sum_calc,
  input  wire logic [ROM_SUM_W-1:0]  rom_sum_stored,
  input  wire logic                  application_load_check,
  input  wire logic                  app_hmac_ok,
  input  wire logic                  key_install,
  output logic [KEY_W-1:0]           nv_key_q,
  input  wire logic                  channel_close,
  input  wire logic                  session_open,
  output logic [KEY_W-1:0]           session_key_q,
  input  wire logic                  apdu_pending,
  output logic                       apdu_exec,
  output logic                       atr_send,
  output logic                       out_enable,
  output logic                       mute
);

  // ***************************************************************
  // State
  // ***************************************************************
  stzs_state_type       state_q, state_d;
  logic [NV_ADDR_W-1:0] addr_q;
  logic                 pass_q;
  logic                 atr_done_q;
  logic [RNG_BLK_W-1:0] trng_prev_q, drng_prev_q;
  logic                 trng_seen_q, drng_seen_q;
  logic                 seed_half_q;

  // ***************************************************************
  // Decode
  // ***************************************************************
  wire kat_ok   = kat_done & (kat_result_eq == KAT_ALL);
  wire crc_ok   = (nv_edc_calc == nv_edc_stored)
                & (rom_sum_calc == rom_sum_stored);
  wire trng_rep = trng.valid & trng_seen_q & (trng.block == trng_prev_q);
  wire drng_rep = drng.valid & drng_seen_q & (drng.block == drng_prev_q);
  wire app_bad  = application_load_check & ~app_hmac_ok;
  wire rng_fail = trng_rep | drng_rep;
  wire fail     = rng_fail | app_bad
                | ((state_q == ST_KAT) & kat_done & ~kat_ok)
                | ((state_q == ST_CRC) & crc_done & ~crc_ok);
  wire erase_end = (addr_q == NV_LAST_ADDR) & pass_q;
  wire seed_take = (state_q == ST_SEED) & trng.valid & ~trng_rep;
  wire is_run    = (state_q == ST_RUN);

  // ***************************************************************
  // Sequencer
  // ***************************************************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_RESUME: state_d = erase_pending ? ST_ERASE : ST_SEED;
      ST_SEED:   if (seed_take & seed_half_q) state_d = ST_KAT;
      ST_KAT:    if (kat_done) state_d = ST_CRC;
      ST_CRC:    if (crc_done) state_d = ST_RUN;
      ST_RUN:    if (erase_cmd) state_d = ST_ERASE;
      ST_ERASE:  if (erase_end) state_d = ST_SEED;
      ST_MUTE:   state_d = ST_MUTE;
      default:   state_d = ST_MUTE;
    endcase
    if (fail) state_d = ST_MUTE;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) state_q <= ST_RESUME;
    else       state_q <= state_d;
  end

  // ***************************************************************
  // Erase walk
  // ***************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      addr_q <= '0;
      pass_q <= 1'b0;
    end else if (state_q == ST_ERASE && !fail) begin
      addr_q <= addr_q + 1'b1;
      if (addr_q == NV_LAST_ADDR) pass_q <= ~pass_q;
    end else begin
      addr_q <= '0;
      pass_q <= 1'b0;
    end
  end

  // Marker stays set in nonvolatile flag until the overwrite pass ends
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nv_wr             <= '0;
      erase_pending_set <= 1'b0;
      erase_pending_clr <= 1'b0;
    end else begin
      nv_wr.we          <= (state_q == ST_ERASE);
      nv_wr.addr        <= addr_q;
      nv_wr.data        <= pass_q ? NV_FILL_PAT : NV_ERASE_PAT;
      erase_pending_set <= is_run & erase_cmd;
      erase_pending_clr <= (state_q == ST_ERASE) & erase_end;
    end
  end

  // ***************************************************************
  // Seeds, keys and generator history
  // ***************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      drng_seed_q     <= BLK_RESET;
      drng_seed_key_q <= BLK_RESET;
      seed_half_q     <= 1'b0;
      drng_seed_load  <= 1'b0;
    end else begin
      drng_seed_load <= seed_take & seed_half_q;
      if (seed_take) begin
        seed_half_q <= ~seed_half_q;
        if (seed_half_q) drng_seed_key_q <= trng.block;
        else             drng_seed_q     <= trng.block;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      trng_prev_q <= BLK_RESET;
      drng_prev_q <= BLK_RESET;
      trng_seen_q <= 1'b0;
      drng_seen_q <= 1'b0;
    end else begin
      if (trng.valid) begin
        trng_prev_q <= trng.block;
        trng_seen_q <= 1'b1;
      end
      if (drng.valid) begin
        drng_prev_q <= drng.block;
        drng_seen_q <= 1'b1;
      end
    end
  end

  // Key takes a fresh random block; old value is gone in the same edge
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nv_key_q      <= KEY_RESET;
      session_key_q <= KEY_RESET;
    end else begin
      if (is_run & key_install & drng.valid & ~drng_rep)
        nv_key_q <= drng.block[KEY_W-1:0];
      if (channel_close | ~is_run)
        session_key_q <= KEY_RESET;
      else if (session_open & drng.valid & ~drng_rep)
        session_key_q <= drng.block[KEY_W-1:0];
    end
  end

  // ***************************************************************
  // Output gating
  // ***************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      atr_done_q <= 1'b0;
      atr_send   <= 1'b0;
      apdu_exec  <= 1'b0;
      out_enable <= 1'b0;
      mute       <= 1'b0;
    end else begin
      atr_done_q <= 1'b1;
      atr_send   <= ~atr_done_q;
      // Held commands wait in the reader link until the run state
      apdu_exec  <= is_run & ~fail & ~erase_cmd & apdu_pending;
      out_enable <= is_run & ~fail;
      mute       <= (state_d == ST_MUTE);
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  sequence s_fail_seen;
    fail;
  endsequence

  property p_mute_sticky;
    @(posedge sys_clk) disable iff (reset) mute |=> mute;
  endproperty
  a_mute_sticky: assert property (p_mute_sticky) else $error("mute left");

  property p_fail_mutes;
    @(posedge sys_clk) disable iff (reset) s_fail_seen |=> mute ##1 !out_enable;
  endproperty
  a_fail_mutes: assert property (p_fail_mutes) else $error("fail not mute");

  property p_out_only_run;
    @(posedge sys_clk) disable iff (reset) out_enable |-> $past(state_q) == ST_RUN;
  endproperty
  a_out_only_run: assert property (p_out_only_run) else $error("output during test");

  property p_exec_after_tests;
    @(posedge sys_clk) disable iff (reset) apdu_exec |-> $past(is_run) && !mute;
  endproperty
  a_exec_after_tests: assert property (p_exec_after_tests) else $error("early apdu");

  property p_resume_erase;
    @(posedge sys_clk) disable iff (reset)
      (state_q == ST_RESUME && erase_pending && !fail) |=> state_q == ST_ERASE;
  endproperty
  a_resume_erase: assert property (p_resume_erase) else $error("erase not resumed");

  property p_no_skip;
    @(posedge sys_clk) disable iff (reset)
      (state_q == ST_RUN && $past(state_q) != ST_RUN) |-> $past(state_q) == ST_CRC;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("test skipped");

  property p_repeat_fails;
    @(posedge sys_clk) disable iff (reset) (trng_rep || drng_rep) |=> state_q == ST_MUTE;
  endproperty
  a_repeat_fails: assert property (p_repeat_fails) else $error("repeat missed");

  property p_app_fail;
    @(posedge sys_clk) disable iff (reset) app_bad |=> mute;
  endproperty
  a_app_fail: assert property (p_app_fail) else $error("app check missed");

  property p_session_clear;
    @(posedge sys_clk) disable iff (reset) channel_close |=> session_key_q == KEY_RESET;
  endproperty
  a_session_clear: assert property (p_session_clear) else $error("session key kept");

  property p_atr_first;
    @(posedge sys_clk) disable iff (reset) $rose(atr_done_q) |-> atr_send ##1 !atr_send;
  endproperty
  a_atr_first: assert property (p_atr_first) else $error("atr missing");

  property p_seed_pair;
    @(posedge sys_clk) disable iff (reset) drng_seed_load |-> $past(state_q) == ST_SEED;
  endproperty
  a_seed_pair: assert property (p_seed_pair) else $error("seed out of order");

  // Overwrite pass must be the one that ends the erase
  property p_two_pass;
    @(posedge sys_clk) disable iff (reset)
      erase_pending_clr |-> $past(pass_q) && nv_wr.data == NV_FILL_PAT;
  endproperty
  a_two_pass: assert property (p_two_pass) else $error("erase cut short");

  property p_kat_fail;
    @(posedge sys_clk) disable iff (reset)
      (state_q == ST_KAT && kat_done && kat_result_eq != KAT_ALL) |=> state_q == ST_MUTE;
  endproperty
  a_kat_fail: assert property (p_kat_fail) else $error("kat miss");

  property p_edc_fail;
    @(posedge sys_clk) disable iff (reset)
      (state_q == ST_CRC && crc_done && nv_edc_calc != nv_edc_stored) |=> state_q == ST_MUTE;
  endproperty
  a_edc_fail: assert property (p_edc_fail) else $error("edc miss");

  property p_rom_fail;
    @(posedge sys_clk) disable iff (reset)
      (state_q == ST_CRC && crc_done && rom_sum_calc != rom_sum_stored) |=> state_q == ST_MUTE;
  endproperty
  a_rom_fail: assert property (p_rom_fail) else $error("rom sum miss");

  // Stored key moves only on an accepted install with a fresh block
  property p_key_fresh;
    @(posedge sys_clk) disable iff (reset)
      $changed(nv_key_q) |->
        $past(key_install) && $past(drng.valid) && $past(state_q) == ST_RUN;
  endproperty
  a_key_fresh: assert property (p_key_fresh) else $error("key changed");

endmodule : stzs_sequencer
`default_nettype wire

// ### tb/stzs_reader.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// Reader side: holds each command until the card runs it
// ********
module stzs_reader (
  input  wire logic sys_clk,
  input  wire logic send,
  input  wire logic apdu_exec,
  output logic      apdu_pending,
  output var int    served
);
  initial begin
    apdu_pending = 1'b0;
    served = 0;
  end
  // Kept across card resets: the card must run it once tests pass
  always @(posedge sys_clk) begin
    if (send) begin
      apdu_pending <= 1'b1;
    end else if (apdu_pending && apdu_exec) begin
      apdu_pending <= 1'b0;
      served <= served + 1;
    end
  end
endmodule : stzs_reader
`default_nettype wire

// ### tb/stzs_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module stzs_sequencer_tb;
  import stzs_pkg::*;
  logic                 sys_clk, reset, erase_pending, erase_cmd, kat_done, crc_done;
  logic                 app_chk, app_ok, key_install, channel_close, session_open, send;
  logic [KAT_COUNT-1:0] kat_eq;
  logic [EDC_W-1:0]     edc_s;
  logic [ROM_SUM_W-1:0] rom_s;
  stzs_rng_type         trng, drng;
  stzs_nv_wr_type       nv_wr;
  logic                 set_p, clr_p, seed_ld, exec, atr, oe, mute, pend;
  logic [RNG_BLK_W-1:0] seed, skey;
  logic [KEY_W-1:0]     nvk, sk;
  int                   bad_count, n_compared, cyc, served;
  localparam logic [63:0] SA = 64'h0123_4567_89ab_cdef;
  localparam logic [63:0] SB = 64'hfedc_ba98_7654_3210;
  localparam int          EW = 2 * (int'(NV_LAST_ADDR) + 1);

  stzs_sequencer uut (.sys_clk(sys_clk), .reset(reset), .erase_pending(erase_pending),
    .erase_pending_set(set_p), .erase_pending_clr(clr_p), .erase_cmd(erase_cmd),
    .nv_wr(nv_wr), .trng_ready(1'b0), .trng(trng), .drng(drng), .drng_seed_load(seed_ld),
    .drng_seed_q(seed), .drng_seed_key_q(skey), .kat_done(kat_done), .kat_result_eq(kat_eq),
    .crc_done(crc_done), .nv_edc_calc(16'h1234), .nv_edc_stored(edc_s),
    .rom_sum_calc(32'h89ab_cdef), .rom_sum_stored(rom_s), .application_load_check(app_chk),
    .app_hmac_ok(app_ok), .key_install(key_install), .nv_key_q(nvk),
    .channel_close(channel_close), .session_open(session_open), .session_key_q(sk),
    .apdu_pending(pend), .apdu_exec(exec), .atr_send(atr), .out_enable(oe), .mute(mute));
  stzs_reader reader (.sys_clk(sys_clk), .send(send), .apdu_exec(exec),
    .apdu_pending(pend), .served(served));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      bad_count++;
      final_report();
    end
  end

  // ********
  // Shared steps
  // ********
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  task automatic do_reset(input logic pe);
    tick(1);
    reset <= 1'b1;
    erase_pending <= pe;
    tick(10);
    @(negedge sys_clk);
    chk("seed_cleared", 64'h0, seed);
    chk("mute_cleared", 64'h0, 64'(mute));
    @(posedge sys_clk);
    reset <= 1'b0;
  endtask : do_reset

  // Keeps counting a few cycles past the clear pulse, which comes with the last write
  task automatic watch_erase(output int n, output logic [15:0] ends, output logic sp,
                             output logic cl);
    int i;
    int post;
    n = 0;
    post = 0;
    sp = 1'b0;
    cl = 1'b0;
    ends = 16'h0;
    for (i = 0; i < 700 && post < 4; i++) begin
      @(negedge sys_clk);
      sp |= (set_p === 1'b1);
      cl |= (clr_p === 1'b1 && nv_wr.addr === NV_LAST_ADDR);
      if (nv_wr.we === 1'b1) begin
        if (n == 0) ends[15:8] = nv_wr.data;
        ends[7:0] = nv_wr.data;
        n++;
      end
      if (clr_p === 1'b1 || post > 0) post++;
    end
  endtask : watch_erase

  task automatic boot(input logic [5:0] kv, input logic [15:0] ed, input logic [31:0] rd,
                      input logic [63:0] b2);
    int i;
    int n;
    int w;
    logic [15:0] ends;
    logic sp;
    logic cl;
    n = 0;
    w = 0;
    // Resumed erase starts writing while the answer-to-reset is watched
    for (i = 0; i < 4; i++) begin
      @(negedge sys_clk);
      n += int'(atr === 1'b1);
      w += int'(nv_wr.we === 1'b1);
    end
    chk("atr_pulses", 64'h1, 64'(n));
    if (erase_pending) begin
      watch_erase(n, ends, sp, cl);
      chk("resume_writes", 64'(EW), 64'(n + w));
      chk("resume_data", 64'({NV_ERASE_PAT, NV_FILL_PAT}), 64'(ends));
      chk("resume_clear", 64'h1, 64'(cl));
    end
    @(posedge sys_clk);
    erase_pending <= 1'b0;
    trng <= '{1'b1, SA};
    tick(1);
    trng <= '{1'b1, b2};
    tick(1);
    trng.valid <= 1'b0;
    for (i = 0; i < 6 && seed_ld !== 1'b1 && mute !== 1'b1; i++) @(negedge sys_clk);
    chk("seed_load", 64'(b2 !== SA), 64'(seed_ld));
    if (b2 !== SA) begin
      chk("seed", SA, seed);
      chk("seed_key", b2, skey);
    end
    chk("out_in_test", 64'h0, 64'(oe | exec));
    @(posedge sys_clk);
    kat_eq <= kv;
    kat_done <= 1'b1;
    tick(1);
    kat_done <= 1'b0;
    tick(2);
    edc_s <= ed;
    rom_s <= rd;
    crc_done <= 1'b1;
    tick(1);
    crc_done <= 1'b0;
    for (i = 0; i < 8 && oe !== 1'b1 && mute !== 1'b1; i++) @(negedge sys_clk);
  endtask : boot

  task automatic expect_state(input logic m);
    chk("mute", 64'(m), 64'(mute));
    chk("out_enable", 64'(!m), 64'(oe));
  endtask : expect_state

  // ********
  // Scenarios
  // ********
  task automatic s_boot_ok;
    do_reset(1'b0);
    send <= 1'b1;
    tick(1);
    send <= 1'b0;
    boot(KAT_ALL, 16'h1234, 32'h89ab_cdef, SB);
    expect_state(1'b0);
    tick(3);
    chk("held_cmd_run", 64'h1, 64'(served));
  endtask : s_boot_ok

  task automatic s_fail_tests;
    int k;
    for (k = 0; k < KAT_COUNT; k++) begin
      do_reset(1'b0);
      boot(KAT_ALL ^ (6'h1 << k), 16'h1234, 32'h89ab_cdef, SB);
      expect_state(1'b1);
    end
    do_reset(1'b0);
    boot(KAT_ALL, 16'h1235, 32'h89ab_cdef, SB);
    expect_state(1'b1);
    do_reset(1'b0);
    boot(KAT_ALL, 16'h1234, 32'h09ab_cdef, SB);
    expect_state(1'b1);
    do_reset(1'b0);
    boot(KAT_ALL, 16'h1234, 32'h89ab_cdef, SA);
    expect_state(1'b1);
    do_reset(1'b0);
    boot(KAT_ALL, 16'h1234, 32'h89ab_cdef, SB);
    @(posedge sys_clk);
    drng <= '{1'b1, SB};
    tick(2);
    drng.valid <= 1'b0;
    tick(2);
    @(negedge sys_clk);
    expect_state(1'b1);
  endtask : s_fail_tests

  task automatic s_run;
    do_reset(1'b0);
    boot(KAT_ALL, 16'h1234, 32'h89ab_cdef, SB);
    @(posedge sys_clk);
    app_ok <= 1'b1;
    app_chk <= 1'b1;
    key_install <= 1'b1;
    session_open <= 1'b1;
    drng <= '{1'b1, 64'h5555_aaaa_cafe_f00d};
    tick(1);
    app_chk <= 1'b0;
    drng.valid <= 1'b0;
    key_install <= 1'b0;
    tick(2);
    chk("session_key_set", 64'h0000_0000_cafe_f00d, 64'(sk));
    channel_close <= 1'b1;
    session_open <= 1'b0;
    tick(1);
    channel_close <= 1'b0;
    tick(3);
    @(negedge sys_clk);
    chk("nv_key", 64'h0000_0000_cafe_f00d, 64'(nvk));
    chk("session_key", 64'h0, 64'(sk));
    expect_state(1'b0);
    @(posedge sys_clk);
    app_chk <= 1'b1;
    app_ok <= 1'b0;
    tick(1);
    app_chk <= 1'b0;
    tick(4);
    send <= 1'b1;
    tick(1);
    send <= 1'b0;
    tick(8);
    @(negedge sys_clk);
    expect_state(1'b1);
    chk("cmd_ignored", 64'h1, 64'(pend & !exec));
  endtask : s_run

  task automatic s_erase;
    int n;
    logic [15:0] ends;
    logic sp;
    logic cl;
    do_reset(1'b0);
    boot(KAT_ALL, 16'h1234, 32'h89ab_cdef, SB);
    @(posedge sys_clk);
    erase_cmd <= 1'b1;
    tick(1);
    erase_cmd <= 1'b0;
    watch_erase(n, ends, sp, cl);
    chk("pending_set", 64'h1, 64'(sp));
    chk("pending_clear", 64'h1, 64'(cl));
    chk("erase_writes", 64'(EW), 64'(n));
    chk("erase_data", 64'({NV_ERASE_PAT, NV_FILL_PAT}), 64'(ends));
    do_reset(1'b1);
    boot(KAT_ALL, 16'h1234, 32'h89ab_cdef, SB);
    expect_state(1'b0);
  endtask : s_erase

  initial begin
    {reset, erase_pending, erase_cmd, kat_done, crc_done, app_chk, app_ok} = '0;
    {key_install, channel_close, session_open, send} = '0;
    reset = 1'b1;
    trng = '0;
    drng = '0;
    kat_eq = '0;
    edc_s = '0;
    rom_s = '0;
    bad_count = 0;
    n_compared = 0;
    s_boot_ok();
    s_fail_tests();
    s_run();
    s_erase();
    final_report();
  end
endmodule : stzs_sequencer_tb
`default_nettype wire
